// ===== sdcb_defines.svh
`ifndef SDCB_DEFINES_SVH
`define SDCB_DEFINES_SVH
`define SDCB_DATA_W 32
`define SDCB_LANES 4
`define SDCB_ADDR_W 11
`define SDCB_COL_W 8
`define SDCB_BANK_W 2
`define SDCB_BANKS 4
`define SDCB_MEM_AW 21
`define SDCB_MODE_W 13
`define SDCB_MODE_RST 13'h0020
`define SDCB_BL_MSB 2
`define SDCB_BL_LSB 0
`define SDCB_BT_BIT 3
`define SDCB_CL_MSB 6
`define SDCB_CL_LSB 4
`define SDCB_WBL_BIT 9
`define SDCB_AP_BIT 10
`define SDCB_CL3_CODE 3'h3
`define SDCB_BL_FULL 3'h7
`endif

// ===== sdcb_pkg.sv
`default_nettype none
package sdcb_pkg;
    typedef enum logic [1:0] {
        SDCB_PWR_RUN = 2'h0,
        SDCB_PWR_SUSPEND = 2'h1,
        SDCB_PWR_DOWN = 2'h2,
        SDCB_PWR_SELFREF = 2'h3
    } sdcb_pwr_type;
    typedef enum logic [1:0] {
        SDCB_BST_NONE = 2'h0,
        SDCB_BST_READ = 2'h1,
        SDCB_BST_WRITE = 2'h2
    } sdcb_burst_type;
    typedef enum logic [3:0] {
        SDCB_CMD_DESEL = 4'h0,
        SDCB_CMD_NOP = 4'h1,
        SDCB_CMD_OPEN = 4'h2,
        SDCB_CMD_CLOSE = 4'h3,
        SDCB_CMD_CLOSE_ALL = 4'h4,
        SDCB_CMD_READ = 4'h5,
        SDCB_CMD_WRITE = 4'h6,
        SDCB_CMD_MODE = 4'h7,
        SDCB_CMD_REFRESH = 4'h8,
        SDCB_CMD_STOP = 4'h9
    } sdcb_cmd_type;

    // Strobe pattern to command; chip select high masks everything
    function automatic sdcb_cmd_type sdcb_decode(input logic cs_n, input logic ras_n,
                                                 input logic cas_n, input logic we_n,
                                                 input logic ap);
        sdcb_cmd_type c;
        c = SDCB_CMD_DESEL;
        if (!cs_n) begin
            unique case ({ras_n, cas_n, we_n})
                3'h7: c = SDCB_CMD_NOP;
                3'h3: c = SDCB_CMD_OPEN;
                3'h2: c = ap ? SDCB_CMD_CLOSE_ALL : SDCB_CMD_CLOSE;
                3'h5: c = SDCB_CMD_READ;
                3'h4: c = SDCB_CMD_WRITE;
                3'h0: c = SDCB_CMD_MODE;
                3'h1: c = SDCB_CMD_REFRESH;
                3'h6: c = SDCB_CMD_STOP;
            endcase
        end
        return c;
    endfunction
endpackage
`default_nettype wire

// ===== sdcb_mem_if.sv
`include "sdcb_defines.svh"
`default_nettype none
interface sdcb_mem_if;
    logic [`SDCB_MEM_AW-1:0] addr;
    logic wr_en;
    logic rd_en;
    logic [`SDCB_LANES-1:0] wr_lane;
    logic [`SDCB_DATA_W-1:0] wdata;
    logic [`SDCB_DATA_W-1:0] rdata;
    modport ctrl (output addr, output wr_en, output rd_en, output wr_lane, output wdata, input rdata);
    modport mem (input addr, input wr_en, input rd_en, input wr_lane, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== sdcb_mem.sv
`include "sdcb_defines.svh"
`default_nettype none
module sdcb_mem (
    input wire logic clk,
    input wire logic sys_rst,
    sdcb_mem_if.mem port
);
    logic [`SDCB_DATA_W-1:0] store [2**`SDCB_MEM_AW];

    // Byte-lane write, one lane per mask bit
    always_ff @(posedge clk) begin
        if (port.wr_en) begin
            for (int i = 0; i < `SDCB_LANES; i++) begin
                if (port.wr_lane[i]) begin
                    store[port.addr][i*8 +: 8] <= port.wdata[i*8 +: 8];
                end
            end
        end
    end

    // Registered read; holds while no read is issued
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            port.rdata <= 32'h00000000;
        end else if (port.rd_en) begin
            port.rdata <= store[port.addr];
        end
    end
endmodule
`default_nettype wire

// ===== sdcb_bank.sv
`include "sdcb_defines.svh"
`default_nettype none
module sdcb_bank (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic open_req,
    input wire logic close_req,
    input wire logic [`SDCB_ADDR_W-1:0] row_in,
    output logic active,
    output logic [`SDCB_ADDR_W-1:0] row
);
    // Close wins so a close-all never leaves a bank half open
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            active <= 1'b0;
            row <= 11'h000;
        end else if (close_req) begin
            active <= 1'b0;
        end else if (open_req) begin
            active <= 1'b1;
            row <= row_in;
        end
    end
endmodule
`default_nettype wire

// ===== sdcb_top.sv
`include "sdcb_defines.svh"
`default_nettype none
//------------------------------------------------------------
// Command decode, bank state and burst data path
//------------------------------------------------------------
// Function
// - Sample all inputs except the asynchronous sys_rst on rising clock edge only
// - Row open loads row into idle bank
// - Bank close returns selected bank to idle
// - Close-all idles every bank, ignores bank select
// - Read starts burst at column, optional autoclose
// - Write starts burst at column, optional autoclose
// - First read word after CAS latency, then consecutive
// - Data pins float once read burst ends
// - Full page bursts run forever, wrap to zero
// - Mask high floats lane two cycles later
// - Read/write, close of the burst bank or close-all cuts a read burst short
// - Read may interrupt read on any cycle
// - Gate fall while bank active enters suspend
// - Gate fall with nop/deselect and all banks idle enters power down
// - Gate rise with nop/deselect leaves power down
// - Power down request during burst becomes suspend
// - Keep previous clock gate level for decoding
// - Burst stop ends a running burst
// - Chip select high ignores all commands
// - Each mask lane covers one data byte
// - Gate low freezes internal state next cycle
// - Mode set loads bank select and address
module sdcb_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic chip_select_n,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic write_strobe_n,
    input wire logic clock_gate_in,
    input wire logic [`SDCB_BANK_W-1:0] bank_sel,
    input wire logic [`SDCB_ADDR_W-1:0] addr,
    input wire logic [`SDCB_LANES-1:0] byte_mask,
    input wire logic [`SDCB_DATA_W-1:0] data_pins_in,
    output logic [`SDCB_DATA_W-1:0] data_pins_out,
    output logic [`SDCB_DATA_W-1:0] data_pins_oe,
    output sdcb_pkg::sdcb_pwr_type power_state,
    output logic [`SDCB_BANKS-1:0] bank_active,
    output logic auto_refresh_pulse
);
    //------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------
    sdcb_mem_if mem_bus ();
    sdcb_pkg::sdcb_pwr_type power_state_reg;
    sdcb_pkg::sdcb_pwr_type power_state_next;
    sdcb_pkg::sdcb_burst_type burst_kind_reg;
    sdcb_pkg::sdcb_cmd_type cmd_raw;
    sdcb_pkg::sdcb_cmd_type cmd;
    logic prev_clock_gate_reg;
    logic [`SDCB_MODE_W-1:0] mode_reg;
    logic [`SDCB_BANK_W-1:0] burst_bank_reg;
    logic [`SDCB_COL_W-1:0] burst_start_reg;
    logic [`SDCB_COL_W-1:0] burst_cnt_reg;
    logic burst_ap_reg;
    logic [`SDCB_ADDR_W-1:0] bank_row [`SDCB_BANKS];
    logic [`SDCB_BANKS-1:0] open_vec;
    logic [`SDCB_BANKS-1:0] close_vec;
    logic [`SDCB_LANES-1:0] mask_d1_reg;
    logic [`SDCB_LANES-1:0] mask_d2_reg;
    logic [`SDCB_LANES-1:0] lane_oe_reg;
    logic [`SDCB_DATA_W-1:0] dout_reg;
    logic [`SDCB_DATA_W-1:0] stage2_reg;
    logic rd_v1_reg;
    logic rd_v2_reg;
    logic refresh_reg;
    logic frozen;
    logic all_idle;
    logic idle_cmd;
    logic read_go;
    logic write_go;
    logic burst_cut;
    logic burst_last;
    logic burst_done;
    logic wr_single_ap;
    logic cl3;
    logic rd_full;
    logic wr_full;
    logic [`SDCB_COL_W-1:0] rd_mask;
    logic [`SDCB_COL_W-1:0] wr_mask;
    logic [`SDCB_COL_W-1:0] cur_mask;
    logic [`SDCB_COL_W-1:0] burst_col;

    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------
    // Burst length code to wrap mask; reserved codes act as length one
    function automatic logic [`SDCB_COL_W-1:0] len_mask(input logic [2:0] code);
        logic [`SDCB_COL_W-1:0] m;
        m = 8'h00;
        unique case (code)
            3'h0: m = 8'h00;
            3'h1: m = 8'h01;
            3'h2: m = 8'h03;
            3'h3: m = 8'h07;
            3'h7: m = 8'hFF;
            default: m = 8'h00;
        endcase
        return m;
    endfunction

    // Column of burst word: wraps inside the burst block, whole row for full page
    function automatic logic [`SDCB_COL_W-1:0] word_col(input logic [`SDCB_COL_W-1:0] start,
                                                        input logic [`SDCB_COL_W-1:0] cnt,
                                                        input logic [`SDCB_COL_W-1:0] m,
                                                        input logic inter);
        logic [`SDCB_COL_W-1:0] low;
        low = inter ? (start ^ cnt) : (start + cnt);
        return (start & ~m) | (low & m);
    endfunction

    //------------------------------------------------------------
    // Command sampling and decode
    //------------------------------------------------------------
    // Previous gate level, paired with the current one to see gate falls and power down exits
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_clock_gate_reg <= 1'b1;
        end else begin
            prev_clock_gate_reg <= clock_gate_in;
        end
    end

    // Internal clock stands still in any mode other than run
    assign frozen = power_state_reg != sdcb_pkg::SDCB_PWR_RUN;
    assign cmd_raw = sdcb_pkg::sdcb_decode(chip_select_n, row_strobe_n, col_strobe_n,
                                           write_strobe_n, addr[`SDCB_AP_BIT]);
    assign cmd = frozen ? sdcb_pkg::SDCB_CMD_NOP : cmd_raw;
    assign idle_cmd = cmd_raw == sdcb_pkg::SDCB_CMD_DESEL || cmd_raw == sdcb_pkg::SDCB_CMD_NOP;
    assign all_idle = ~|bank_active;

    // Access commands only count against an open bank
    assign read_go = cmd == sdcb_pkg::SDCB_CMD_READ && bank_active[bank_sel];
    assign write_go = cmd == sdcb_pkg::SDCB_CMD_WRITE && bank_active[bank_sel];

    //------------------------------------------------------------
    // Mode register
    //------------------------------------------------------------
    // Reset value stands in for the undefined power-up contents
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_reg <= `SDCB_MODE_RST;
        end else if (cmd == sdcb_pkg::SDCB_CMD_MODE && all_idle) begin
            mode_reg <= {bank_sel, addr};
        end
    end

    assign cl3 = mode_reg[`SDCB_CL_MSB:`SDCB_CL_LSB] == `SDCB_CL3_CODE;
    assign rd_mask = len_mask(mode_reg[`SDCB_BL_MSB:`SDCB_BL_LSB]);
    assign rd_full = mode_reg[`SDCB_BL_MSB:`SDCB_BL_LSB] == `SDCB_BL_FULL;
    // Single-write mode shortens write bursts only
    assign wr_mask = mode_reg[`SDCB_WBL_BIT] ? 8'h00 : rd_mask;
    assign wr_full = rd_full && !mode_reg[`SDCB_WBL_BIT];

    //------------------------------------------------------------
    // Bank state
    //------------------------------------------------------------
    // A write with autoclose of length one shuts its bank at once; a read waits for its burst to end
    assign wr_single_ap = write_go && addr[`SDCB_AP_BIT] && wr_mask == 8'h00 && !wr_full;

    generate
        for (genvar b = 0; b < `SDCB_BANKS; b++) begin : g_bank
            assign open_vec[b] = cmd == sdcb_pkg::SDCB_CMD_OPEN && bank_sel == b
                                 && !bank_active[b];
            assign close_vec[b] = (cmd == sdcb_pkg::SDCB_CMD_CLOSE && bank_sel == b)
                                  || cmd == sdcb_pkg::SDCB_CMD_CLOSE_ALL
                                  || (burst_done && burst_ap_reg && burst_bank_reg == b)
                                  || (wr_single_ap && bank_sel == b);
            sdcb_bank u_bank (
                .clk(clk),
                .sys_rst(sys_rst),
                .open_req(open_vec[b]),
                .close_req(close_vec[b]),
                .row_in(addr),
                .active(bank_active[b]),
                .row(bank_row[b])
            );
        end
    endgenerate

    //------------------------------------------------------------
    // Burst sequencer
    //------------------------------------------------------------
    assign cur_mask = burst_kind_reg == sdcb_pkg::SDCB_BST_WRITE ? wr_mask : rd_mask;
    assign burst_col = word_col(burst_start_reg, burst_cnt_reg, cur_mask, mode_reg[`SDCB_BT_BIT]);
    // Full page never reaches a last word
    assign burst_last = burst_cnt_reg == cur_mask
                        && !(burst_kind_reg == sdcb_pkg::SDCB_BST_WRITE ? wr_full : rd_full);
    // Commands that cut a running burst; nop and deselect are absent
    assign burst_cut = read_go || write_go || cmd == sdcb_pkg::SDCB_CMD_STOP
                       || cmd == sdcb_pkg::SDCB_CMD_CLOSE_ALL
                       || (cmd == sdcb_pkg::SDCB_CMD_CLOSE && bank_sel == burst_bank_reg);
    assign burst_done = burst_kind_reg != sdcb_pkg::SDCB_BST_NONE && !frozen
                        && (burst_cut || burst_last);

    // New access restarts the sequencer on any cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            burst_kind_reg <= sdcb_pkg::SDCB_BST_NONE;
            burst_bank_reg <= 2'h0;
            burst_start_reg <= 8'h00;
            burst_cnt_reg <= 8'h00;
            burst_ap_reg <= 1'b0;
        end else if (!frozen) begin
            if (read_go) begin
                burst_kind_reg <= sdcb_pkg::SDCB_BST_READ;
                burst_bank_reg <= bank_sel;
                burst_start_reg <= addr[`SDCB_COL_W-1:0];
                burst_cnt_reg <= 8'h00;
                burst_ap_reg <= addr[`SDCB_AP_BIT];
            end else if (write_go) begin
                // First word is taken with the command itself
                burst_kind_reg <= (wr_mask == 8'h00 && !wr_full) ? sdcb_pkg::SDCB_BST_NONE
                                                                  : sdcb_pkg::SDCB_BST_WRITE;
                burst_bank_reg <= bank_sel;
                burst_start_reg <= addr[`SDCB_COL_W-1:0];
                burst_cnt_reg <= 8'h01;
                burst_ap_reg <= addr[`SDCB_AP_BIT];
            end else if (burst_done) begin
                burst_kind_reg <= sdcb_pkg::SDCB_BST_NONE;
            end else if (burst_kind_reg != sdcb_pkg::SDCB_BST_NONE) begin
                burst_cnt_reg <= burst_cnt_reg + 8'h01;
            end
        end
    end

    //------------------------------------------------------------
    // Memory port
    //------------------------------------------------------------
    // Write command owns the port in its own cycle; the read word is dropped
    assign mem_bus.addr = write_go ? {bank_sel, bank_row[bank_sel], addr[`SDCB_COL_W-1:0]}
                                   : {burst_bank_reg, bank_row[burst_bank_reg], burst_col};
    assign mem_bus.wr_en = !frozen && (write_go
                           || (burst_kind_reg == sdcb_pkg::SDCB_BST_WRITE && !burst_cut));
    assign mem_bus.rd_en = !frozen && !write_go && burst_kind_reg == sdcb_pkg::SDCB_BST_READ;
    assign mem_bus.wr_lane = ~byte_mask;
    assign mem_bus.wdata = data_pins_in;

    sdcb_mem u_mem (
        .clk(clk),
        .sys_rst(sys_rst),
        .port(mem_bus.mem)
    );

    //------------------------------------------------------------
    // Read pipeline and output drivers
    //------------------------------------------------------------
    // Mask delay line; the output register adds the second cycle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask_d1_reg <= 4'h0;
            mask_d2_reg <= 4'h0;
        end else if (!frozen) begin
            mask_d1_reg <= byte_mask;
            mask_d2_reg <= mask_d1_reg;
        end
    end

    // Latency two takes memory data direct, three via one more stage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_v1_reg <= 1'b0;
            rd_v2_reg <= 1'b0;
            stage2_reg <= 32'h00000000;
            dout_reg <= 32'h00000000;
            lane_oe_reg <= 4'h0;
        end else if (!frozen) begin
            rd_v1_reg <= mem_bus.rd_en;
            rd_v2_reg <= rd_v1_reg;
            stage2_reg <= mem_bus.rdata;
            dout_reg <= cl3 ? stage2_reg : mem_bus.rdata;
            // Lanes float when no word is due or the mask was high
            lane_oe_reg <= {`SDCB_LANES{cl3 ? rd_v2_reg : rd_v1_reg}} & ~mask_d2_reg;
        end
    end

    assign data_pins_out = dout_reg;
    generate
        for (genvar l = 0; l < `SDCB_LANES; l++) begin : g_lane
            assign data_pins_oe[l*8 +: 8] = {8{lane_oe_reg[l]}};
        end
    endgenerate

    //------------------------------------------------------------
    // Power modes
    //------------------------------------------------------------
    // Power down is refused while a burst runs or a bank is open
    always_comb begin
        power_state_next = power_state_reg;
        unique case (power_state_reg)
            sdcb_pkg::SDCB_PWR_RUN: begin
                if (prev_clock_gate_reg && !clock_gate_in) begin
                    if (cmd == sdcb_pkg::SDCB_CMD_REFRESH && all_idle) begin
                        power_state_next = sdcb_pkg::SDCB_PWR_SELFREF;
                    end else if (burst_kind_reg != sdcb_pkg::SDCB_BST_NONE) begin
                        power_state_next = sdcb_pkg::SDCB_PWR_SUSPEND;
                    end else if (!all_idle) begin
                        power_state_next = sdcb_pkg::SDCB_PWR_SUSPEND;
                    end else if (idle_cmd) begin
                        power_state_next = sdcb_pkg::SDCB_PWR_DOWN;
                    end else begin
                        power_state_next = sdcb_pkg::SDCB_PWR_SUSPEND;
                    end
                end
            end
            sdcb_pkg::SDCB_PWR_SUSPEND: begin
                if (clock_gate_in) begin
                    power_state_next = sdcb_pkg::SDCB_PWR_RUN;
                end
            end
            sdcb_pkg::SDCB_PWR_DOWN: begin
                if (!prev_clock_gate_reg && clock_gate_in && idle_cmd) begin
                    power_state_next = sdcb_pkg::SDCB_PWR_RUN;
                end
            end
            sdcb_pkg::SDCB_PWR_SELFREF: begin
                if (clock_gate_in && idle_cmd) begin
                    power_state_next = sdcb_pkg::SDCB_PWR_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            power_state_reg <= sdcb_pkg::SDCB_PWR_RUN;
        end else begin
            power_state_reg <= power_state_next;
        end
    end

    // One auto refresh per command; no row retention model is needed
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            refresh_reg <= 1'b0;
        end else begin
            refresh_reg <= cmd == sdcb_pkg::SDCB_CMD_REFRESH && all_idle && clock_gate_in;
        end
    end

    assign power_state = power_state_reg;
    assign auto_refresh_pulse = refresh_reg;
endmodule
`default_nettype wire

// ===== sdcb_props.sv
`default_nettype none
module sdcb_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic chip_select_n,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic write_strobe_n,
    input wire logic clock_gate_in,
    input wire logic [1:0] bank_sel,
    input wire logic [10:0] addr,
    input wire logic [3:0] byte_mask,
    input wire logic [31:0] data_pins_oe,
    input wire sdcb_pkg::sdcb_pwr_type power_state,
    input wire logic [3:0] bank_active
);
    timeunit 1ns;
    timeprecision 1ps;
    logic run, idle_c, open_c, close_c;
    // Strobe decode; run is the state before the edge, which gates acceptance
    assign run = power_state == sdcb_pkg::SDCB_PWR_RUN;
    assign idle_c = chip_select_n | (row_strobe_n & col_strobe_n & write_strobe_n);
    assign open_c = !chip_select_n & !row_strobe_n & col_strobe_n & write_strobe_n;
    assign close_c = !chip_select_n & !row_strobe_n & col_strobe_n & !write_strobe_n;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    open_bank_a: assert property (run && open_c |=> bank_active[$past(bank_sel)])
        else $error("opened bank not active");
    close_bank_a: assert property (run && close_c && !addr[10] |=> !bank_active[$past(bank_sel)])
        else $error("closed bank still active");
    close_all_a: assert property (run && close_c && addr[10] |=> bank_active == 4'h0)
        else $error("bank left open by close all");
    deselect_a: assert property (run && chip_select_n |=> (bank_active & ~$past(bank_active)) == 4'h0)
        else $error("bank opened while deselected");
    // Frozen cycles stretch the mask pipe, so only unbroken running spans are judged
    for (genvar i = 0; i < 4; i++) begin : g_lane
        mask_lane_a: assert property (data_pins_oe[8*i+:8] != 8'h00 && $past(clock_gate_in) &&
            $past(clock_gate_in, 2) && $past(clock_gate_in, 3) |-> !$past(byte_mask[i], 3))
            else $error("masked lane drove data");
    end
    pd_entry_a: assert property (run && $fell(clock_gate_in) && idle_c |=> power_state != sdcb_pkg::SDCB_PWR_RUN)
        else $error("no power down on gate fall");
    suspend_entry_a: assert property (run && $fell(clock_gate_in) && bank_active != 4'h0
        |=> power_state == sdcb_pkg::SDCB_PWR_SUSPEND) else $error("no suspend with open bank");
    pd_exit_a: assert property (power_state == sdcb_pkg::SDCB_PWR_DOWN && $rose(clock_gate_in) && idle_c
        |=> run) else $error("power down not left");
    cover property (data_pins_oe == 32'hFFFF_FFFF);
    cover property (power_state == sdcb_pkg::SDCB_PWR_DOWN);
    cover property (power_state == sdcb_pkg::SDCB_PWR_SUSPEND);
endmodule
`default_nettype wire

// ===== sdcb_host_model.sv
`default_nettype none
module sdcb_host_model #(parameter int GAP = 2) (
    input wire logic clk,
    output logic [3:0] strobes_n,
    output logic clock_gate_in,
    output logic [1:0] bank_sel,
    output logic [10:0] addr,
    output logic [3:0] byte_mask,
    output logic [31:0] data_pins_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Deselected with the gate running at time zero
    initial begin
        strobes_n = 4'hF;
        clock_gate_in = 1'b1;
        bank_sel = 2'h0;
        addr = 11'h000;
        byte_mask = 4'h0;
        data_pins_in = 32'h0000_0000;
    end
    // Called just after a falling edge; strobes are chip select, row, column, write
    task automatic cmd(input logic [3:0] s, input logic [1:0] b, input logic [10:0] a, input logic [31:0] d);
        strobes_n = s;
        bank_sel = b;
        addr = a;
        data_pins_in = d;
        @(negedge clk);
    endtask
    // A released bus never keeps showing the last word
    task automatic nop(input int n);
        strobes_n = 4'h7;
        data_pins_in = ~data_pins_in;
        repeat (n) @(negedge clk);
    endtask
    task automatic act(input logic [1:0] b, input logic [10:0] row);
        cmd(4'h3, b, row, 32'h0000_0000);
        nop(GAP);
    endtask
    task automatic pins(input logic g, input logic [3:0] m);
        clock_gate_in = g;
        byte_mask = m;
    endtask
endmodule
`default_nettype wire

// ===== test_sdcb_command_bank_control.sv
`default_nettype none
module test_sdcb_command_bank_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, sys_rst, gate, refr;
    logic [3:0] stb, mask, banks;
    logic [1:0] bank;
    logic [10:0] addr;
    logic [31:0] din, dout, oe;
    sdcb_pkg::sdcb_pwr_type pwr;
    int errors, samples_checked;
    sdcb_host_model i_host (.clk(clk), .strobes_n(stb), .clock_gate_in(gate), .bank_sel(bank), .addr(addr),
        .byte_mask(mask), .data_pins_in(din));
    sdcb_top i_dut (.clk(clk), .sys_rst(sys_rst), .chip_select_n(stb[3]), .row_strobe_n(stb[2]),
        .col_strobe_n(stb[1]), .write_strobe_n(stb[0]), .clock_gate_in(gate), .bank_sel(bank), .addr(addr),
        .byte_mask(mask), .data_pins_in(din), .data_pins_out(dout), .data_pins_oe(oe), .power_state(pwr),
        .bank_active(banks), .auto_refresh_pulse(refr));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checked %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Back-to-back reads, the second one with lane 2 masked
    task automatic t_read_pair;
        i_host.act(2'h1, 11'h005);
        chk({28'h0, banks}, 32'h0000_0002);
        i_host.cmd(4'h4, 2'h1, 11'h003, 32'hA5C3_1E87);
        i_host.cmd(4'h5, 2'h1, 11'h003, 32'h0000_0000);
        i_host.pins(1'b1, 4'h4);
        i_host.cmd(4'h5, 2'h1, 11'h003, 32'h0000_0000);
        i_host.pins(1'b1, 4'h0);
        i_host.nop(1);
        chk(oe, 32'hFFFF_FFFF);
        chk(dout, 32'hA5C3_1E87);
        i_host.nop(1);
        chk(oe, 32'hFF00_FFFF);
        i_host.nop(1);
        chk(oe, 32'h0000_0000);
    endtask
    // All-bank close, latency three after a mode set, then a single close and a deselected command
    task automatic t_cl3;
        i_host.cmd(4'h2, 2'h0, 11'h400, 32'h0000_0000);
        i_host.nop(1);
        chk({28'h0, banks}, 32'h0000_0000);
        i_host.cmd(4'h0, 2'h0, 11'h030, 32'h0000_0000);
        i_host.act(2'h0, 11'h011);
        i_host.act(2'h2, 11'h007);
        i_host.cmd(4'h4, 2'h2, 11'h009, 32'h3C5A_96F0);
        i_host.cmd(4'h5, 2'h2, 11'h009, 32'h0000_0000);
        i_host.nop(2);
        chk(oe, 32'h0000_0000);
        i_host.nop(1);
        chk(oe, 32'hFFFF_FFFF);
        chk(dout, 32'h3C5A_96F0);
        i_host.cmd(4'h2, 2'h2, 11'h000, 32'h0000_0000);
        i_host.cmd(4'hB, 2'h3, 11'h000, 32'h0000_0000);
        i_host.nop(1);
        chk({28'h0, banks}, 32'h0000_0001);
    endtask
    // Power down with banks idle, clock suspend with a bank open
    task automatic t_power;
        i_host.cmd(4'h2, 2'h0, 11'h400, 32'h0000_0000);
        i_host.nop(1);
        i_host.pins(1'b0, 4'h0);
        i_host.nop(2);
        chk({30'h0, pwr}, {30'h0, sdcb_pkg::SDCB_PWR_DOWN});
        i_host.pins(1'b1, 4'h0);
        i_host.nop(2);
        chk({30'h0, pwr}, {30'h0, sdcb_pkg::SDCB_PWR_RUN});
        i_host.act(2'h3, 11'h123);
        i_host.pins(1'b0, 4'h0);
        i_host.nop(2);
        chk({30'h0, pwr}, {30'h0, sdcb_pkg::SDCB_PWR_SUSPEND});
        i_host.pins(1'b1, 4'h0);
        i_host.nop(2);
        chk({28'h0, banks}, 32'h0000_0008);
        i_host.cmd(4'h2, 2'h0, 11'h400, 32'h0000_0000);
        i_host.cmd(4'h1, 2'h0, 11'h000, 32'h0000_0000);
        chk({31'h0, refr}, 32'h0000_0001);
        i_host.nop(2);
        chk({31'h0, refr}, 32'h0000_0000);
        // Full page read runs past where an eight-word burst would stop, until burst stop
        i_host.cmd(4'h0, 2'h0, 11'h027, 32'h0000_0000);
        i_host.act(2'h1, 11'h005);
        i_host.cmd(4'h5, 2'h1, 11'h003, 32'h0000_0000);
        i_host.nop(10);
        chk(oe, 32'hFFFF_FFFF);
        i_host.cmd(4'h6, 2'h1, 11'h000, 32'h0000_0000);
        i_host.nop(2);
        chk(oe, 32'h0000_0000);
    endtask
    initial begin
        sys_rst = 1'b1;
        errors = 0;
        samples_checked = 0;
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        chk(oe, 32'h0000_0000);
        t_read_pair;
        t_cl3;
        t_power;
        end_sim;
    end
    // Watchdog well past the roughly 80 cycles the tests take
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        end_sim;
    end
endmodule
// Every checker port carries the same name as a port of the bound module
bind sdcb_top sdcb_props i_props (.*);
`default_nettype wire
